// ==== design/gtmr_timer.v ====
// Gated sixteen-bit timer with AHB-Lite register access.
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`include "gtmr_defs.vh"

// How the block behaves at its register port.
// The slave answers every transfer at once: hreadyout is tied high and the response is OKAY.
// An address phase is latched at the rising edge that accepts it.
// A write lands at the edge that ends its data phase.
// Read data is registered from the address phase and stands through the data phase.
// It then holds until the next read address phase.
// Each register takes one aligned word, and only the low byte carries bits.
// Unmapped offsets read as zero, and writes to them are dropped.

// How the count advances.
// Every count source is reduced to a one-cycle tick on the bus clock.
// The instruction source is a free-running divide-by-four of that clock.
// It is not cleared by register writes, so the first increment after a start may come early.
// The slow oscillator input is taken as a ready-made one-cycle enable pulse.
// The pin source is edge-detected, after two flip-flops or straight from the pin.
// The straight path is meant for counting while the bus clock is gated in sleep.
// On a live clock it still relies on the pin being held steady around the sampling edge.
// A fresh start or a count write disarms the pin path until a low level is seen.
// This keeps a pin that is already high from yielding a false first increment.

// How the prescaler works.
// The prescaler counts accepted ticks only, so a closed gate freezes its phase as well.
// It is cleared by any write to either count byte, never by a control write.
// Changing the divide ratio while running may shorten the first divided period.

// How the gate works.
// The selected gate source is used combinationally for counting.
// A gate that moves between ticks is therefore honoured at the very next tick.
// The registered gate level output lags the counting decision by one clock.
// The neighbour rollover source is an edge detector, so a long high level opens the gate once.
// The comparator sources can each be taken raw or after two flip-flops.

// Hazards that software must keep in mind.
// A count write wins over an increment in the same cycle.
// The written byte is then exact, but the other byte keeps its previous value.
// Writing while counting from a free-running pin may still land next to an edge.
// Stopping the timer before such writes avoids any doubt.
// The overflow flag set wins over a clear in the same cycle.
// A rollover is therefore never lost to a late clear.
// The wake request is combinational and drops as soon as the flag is cleared.
module gtmr_timer #(
    parameter CNT_W = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire ext_clock_pin,
    input wire low_freq_internal_osc,
    input wire sec_osc_clock,
    input wire gate_pin,
    input wire neighbour_8bit_timer_ovf,
    input wire cmp1_out,
    input wire cmp2_out,
    input wire sleep_mode,
    output reg sec_osc_run,
    output reg overflow_flag,
    output wire wake_request,
    output reg gate_level
);

    // Data-phase bookkeeping for the single-cycle slave.
    reg dp_write;
    reg dp_read;
    reg [11:0] dp_addr;
    reg [7:0] timer_control_reg;
    reg [7:0] gate_control_reg;
    reg [CNT_W-1:0] count;
    reg [2:0] prescale_cnt;
    reg [1:0] inst_div;
    reg pin_s1;
    reg pin_s2;
    reg pin_prev;
    reg armed;
    reg cmp1_s1;
    reg cmp1_s2;
    reg cmp2_s1;
    reg cmp2_s2;
    reg nbr_prev;
    reg gate_raw;
    reg tick;
    reg [2:0] ps_mask;
    reg [7:0] next_count_byte;
    wire run_bit;
    wire gate_enable_bit;
    wire gate_polarity_bit;
    wire sync_control_bit;
    wire sec_osc_enable;
    wire [1:0] clock_source_select;
    wire [1:0] prescale_select;
    wire [1:0] gate_source_select;
    wire wr_low;
    wire wr_high;
    wire count_write;
    wire src_pin_level;
    wire pin_level;
    wire nbr_pulse;
    wire count_en;
    wire pre_out;

    // Byte write that always takes the low eight-bit lane of the word; the old value is ignored.
    function [7:0] merge_byte;
        input [7:0] old_val;
        input [31:0] wdata;
        begin
            merge_byte = wdata[7:0];
        end
    endfunction

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign run_bit = timer_control_reg[`GTMR_CTRL_RUN];
    assign sync_control_bit = timer_control_reg[`GTMR_CTRL_SYNC];
    assign sec_osc_enable = timer_control_reg[`GTMR_CTRL_SOSC];
    assign prescale_select = timer_control_reg[`GTMR_CTRL_PS_LO +: 2];
    assign clock_source_select = timer_control_reg[`GTMR_CTRL_CS_LO +: 2];
    assign gate_source_select = gate_control_reg[`GTMR_GATE_SS_LO +: 2];
    assign gate_polarity_bit = gate_control_reg[`GTMR_GATE_POL];
    assign gate_enable_bit = gate_control_reg[`GTMR_GATE_EN];
    assign wr_low = dp_write && (dp_addr == `GTMR_OFS_LOW);
    assign wr_high = dp_write && (dp_addr == `GTMR_OFS_HIGH);
    assign count_write = wr_low || wr_high;

    // Latch the address phase; the slave never inserts wait states.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 12'h000;
        end else if (hready) begin
            dp_write <= hsel && htrans[1] && hwrite;
            dp_read <= hsel && htrans[1] && !hwrite;
            dp_addr <= {haddr[11:2], 2'b00};
        end
    end

    // Read data is registered from the live count so a byte is never torn.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case ({haddr[11:2], 2'b00})
                `GTMR_OFS_LOW: hrdata <= {24'h000000, count[7:0]};
                `GTMR_OFS_HIGH: hrdata <= {24'h000000, count[15:8]};
                `GTMR_OFS_CTRL: hrdata <= {24'h000000, timer_control_reg};
                `GTMR_OFS_GATE: hrdata <= {24'h000000, gate_control_reg};
                `GTMR_OFS_STAT: hrdata <= {30'h0, wake_request, overflow_flag};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // Control registers; reset leaves the timer off, instruction clock, 1:1.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control_reg <= `GTMR_CTRL_RESET;
            gate_control_reg <= `GTMR_GATE_RESET;
        end else begin
            if (dp_write && dp_addr == `GTMR_OFS_CTRL) begin
                timer_control_reg <= hwdata[7:0] & 8'hfd;
            end
            if (dp_write && dp_addr == `GTMR_OFS_GATE) begin
                gate_control_reg <= hwdata[7:0] & 8'hcf;
            end
        end
    end

    // The oscillator request stays up through sleep; only software or reset drops it.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_osc_run <= 1'b0;
        end else begin
            sec_osc_run <= sec_osc_enable;
        end
    end

    // Pin source: the crystal when enabled, otherwise the external clock pin.
    assign src_pin_level = sec_osc_enable ? sec_osc_clock : ext_clock_pin;

    // Two-stage synchroniser; the unsynchronised path takes the pin as is.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            pin_s1 <= src_pin_level;
            pin_s2 <= pin_s1;
        end
    end

    // Switching sync mode changes the path delay, which can drop or add one edge.
    assign pin_level = sync_control_bit ? src_pin_level : pin_s2;

    // Comparator synchronisers, chosen per comparator by its sync bit.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp1_s1 <= 1'b0;
            cmp1_s2 <= 1'b0;
            cmp2_s1 <= 1'b0;
            cmp2_s2 <= 1'b0;
            nbr_prev <= 1'b0;
        end else begin
            cmp1_s1 <= cmp1_out;
            cmp1_s2 <= cmp1_s1;
            cmp2_s1 <= cmp2_out;
            cmp2_s2 <= cmp2_s1;
            nbr_prev <= neighbour_8bit_timer_ovf;
        end
    end

    // A single low-to-high pulse per neighbour rollover.
    assign nbr_pulse = neighbour_8bit_timer_ovf && !nbr_prev;

    // Gate source mux.
    always @* begin
        case (gate_source_select)
            `GTMR_GS_PIN: gate_raw = gate_pin;
            `GTMR_GS_NBR: gate_raw = nbr_pulse;
            `GTMR_GS_CMP1: gate_raw = gate_control_reg[`GTMR_GATE_C1SYNC] ? cmp1_s2 : cmp1_out;
            `GTMR_GS_CMP2: gate_raw = gate_control_reg[`GTMR_GATE_C2SYNC] ? cmp2_s2 : cmp2_out;
            default: gate_raw = gate_pin;
        endcase
    end

    // Gate level after polarity: polarity 1 counts on high, 0 counts on low.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_level <= 1'b0;
        end else begin
            gate_level <= gate_raw ~^ gate_polarity_bit;
        end
    end

    // Off without run; gated mode counts only while the gate permits.
    assign count_en = run_bit && (!gate_enable_bit || (gate_raw ~^ gate_polarity_bit));

    // Instruction clock is one enable every four system clocks.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inst_div <= 2'h0;
        end else begin
            inst_div <= inst_div + 2'h1;
        end
    end

    // Pin edge tracking; a fresh arm needs a low level before the first rise.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_prev <= 1'b0;
            armed <= 1'b0;
        end else begin
            pin_prev <= pin_level;
            if (count_write || !run_bit) begin
                armed <= 1'b0;
            end else if (!pin_level) begin
                armed <= 1'b1;
            end
        end
    end

    // Source select picks one tick per input rising edge.
    always @* begin
        case (clock_source_select)
            `GTMR_CS_INST: tick = (inst_div == `GTMR_INST_DIV);
            `GTMR_CS_SYS: tick = 1'b1;
            `GTMR_CS_PIN: tick = pin_level && !pin_prev && armed;
            `GTMR_CS_LFO: tick = low_freq_internal_osc;
            default: tick = 1'b0;
        endcase
    end

    // Divide mask for 1, 2, 4 or 8.
    always @* begin
        case (prescale_select)
            2'h0: ps_mask = 3'h0;
            2'h1: ps_mask = 3'h1;
            2'h2: ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    end

    assign pre_out = ((prescale_cnt & ps_mask) == ps_mask);

    // Hidden prescaler, cleared by any count byte write.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale_cnt <= 3'h0;
        end else if (count_write) begin
            prescale_cnt <= 3'h0;
        end else if (count_en && tick) begin
            prescale_cnt <= prescale_cnt + 3'h1;
        end
    end

    // Byte writes take priority over a colliding increment.
    always @* begin
        next_count_byte = merge_byte(8'h00, hwdata);
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= {CNT_W{1'b0}};
        end else if (wr_low) begin
            count[7:0] <= next_count_byte;
        end else if (wr_high) begin
            count[15:8] <= next_count_byte;
        end else if (count_en && tick && pre_out) begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Rollover sets the flag; a same-cycle software clear loses to the set.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_flag <= 1'b0;
        end else if (!count_write && count_en && tick && pre_out && (&count)) begin
            overflow_flag <= 1'b1;
        end else if (dp_write && dp_addr == `GTMR_OFS_STAT && hwdata[`GTMR_STAT_OVF]) begin
            overflow_flag <= 1'b0;
        end
    end

    // Wake only for an unsynchronised pin count during sleep.
    assign wake_request = overflow_flag && sleep_mode && sync_control_bit
        && (clock_source_select == `GTMR_CS_PIN);

endmodule // gtmr_timer

// ==== design/gtmr_defs.vh ====
// Register map, field positions, source codes and reset values for the gated timer.
`ifndef GTMR_DEFS_VH
`define GTMR_DEFS_VH
`define GTMR_OFS_LOW 12'h000
`define GTMR_OFS_HIGH 12'h004
`define GTMR_OFS_CTRL 12'h008
`define GTMR_OFS_GATE 12'h00c
`define GTMR_OFS_STAT 12'h010
`define GTMR_CTRL_RUN 0
`define GTMR_CTRL_SYNC 2
`define GTMR_CTRL_SOSC 3
`define GTMR_CTRL_PS_LO 4
`define GTMR_CTRL_CS_LO 6
`define GTMR_GATE_SS_LO 0
`define GTMR_GATE_C1SYNC 2
`define GTMR_GATE_C2SYNC 3
`define GTMR_GATE_POL 6
`define GTMR_GATE_EN 7
`define GTMR_STAT_OVF 0
`define GTMR_STAT_WAKE 1
`define GTMR_CS_INST 2'h0
`define GTMR_CS_SYS 2'h1
`define GTMR_CS_PIN 2'h2
`define GTMR_CS_LFO 2'h3
`define GTMR_GS_PIN 2'h0
`define GTMR_GS_NBR 2'h1
`define GTMR_GS_CMP1 2'h2
`define GTMR_GS_CMP2 2'h3
`define GTMR_INST_DIV 2'h3
`define GTMR_CTRL_RESET 8'h00
`define GTMR_GATE_RESET 8'h00
`endif

// ==== sim/gtmr_pins.sv ====
// Far-side pin model: count clock, gate pin, comparators and neighbour overflow.
`timescale 1ns/10ps
module gtmr_pins #(
    parameter int HALF_NS = 30
) (
    output logic ext_clock_pin,
    output logic gate_pin,
    output logic cmp1_out,
    output logic cmp2_out,
    output logic nbr_ovf
);
    // The count clock idles high, so every burst opens with a falling edge.
    initial begin
        ext_clock_pin = 1'b1;
        gate_pin = 1'b1;
        cmp1_out = 1'b1;
        cmp2_out = 1'b0;
        nbr_ovf = 1'b0;
    end
    // A larger HALF_NS models a slow source; each pulse ends high.
    // The short lead-in keeps every pin change off a clock edge.
    task automatic pulses(input int n);
        #3;
        repeat (n) begin
            #(HALF_NS) ext_clock_pin = 1'b0;
            #(HALF_NS) ext_clock_pin = 1'b1;
        end
    endtask
    // Neighbour rollovers; each high stretch spans several clocks but is one event.
    task automatic nbr_pulses(input int n);
        #3;
        repeat (n) begin
            #(HALF_NS) nbr_ovf = 1'b1;
            #(HALF_NS) nbr_ovf = 1'b0;
        end
    endtask
endmodule  // gtmr_pins

// ==== sim/gtmr_timer_monitor.sv ====
// Port checks for the gated timer, bound to its top module.
`timescale 1ns/10ps
module gtmr_monitor (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire gate_pin,
    input wire cmp1_out,
    input wire cmp2_out,
    input wire sleep_mode,
    input wire sec_osc_run,
    input wire overflow_flag,
    input wire wake_request,
    input wire gate_level
);
    reg [7:0] csh, gsh;
    reg [11:0] da;
    reg dw, dr;
    // Selected gate source; synchronised comparators are skipped for their extra delay, the neighbour source as well.
    wire [1:0] gs = gsh[1:0];
    wire src = gs == 2'h0 ? gate_pin : gs == 2'h2 ? cmp1_out : cmp2_out;
    wire raw = gs == 2'h2 ? !gsh[2] : gs == 2'h3 ? !gsh[3] : gs == 2'h0;
    wire g_ok = hresetn && gsh[7] && raw;
    wire g_exp = src ~^ gsh[6];
    wire clr = dw && da == 12'h010 && hwdata[0];
    wire wk = overflow_flag && sleep_mode && csh[2] && csh[7:6] == 2'h2;
    // Shadows of control and gate registers; a write lands as its data phase ends.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {csh, gsh, da, dw, dr} <= 30'h0;
        end else begin
            dw <= hsel && hreadyout && htrans[1] && hwrite;
            dr <= hsel && hreadyout && htrans[1] && !hwrite;
            da <= haddr;
            csh <= (dw && da == 12'h008) ? hwdata[7:0] : csh;
            gsh <= (dw && da == 12'h00c) ? hwdata[7:0] : gsh;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_BUS: assert property (hreadyout && !hresp)
        else $error("bus wait or error");
    AST_RST: assert property ($rose(hresetn) |-> !overflow_flag && !sec_osc_run)
        else $error("output set out of reset");
    AST_GATE: assert property ($past(g_ok) |-> gate_level == $past(g_exp))
        else $error("gate level wrong");
    AST_WAKE: assert property (wake_request == wk)
        else $error("wake request wrong");
    AST_SOSC: assert property ($changed(csh[3]) |-> ##[0:1] sec_osc_run == csh[3])
        else $error("oscillator run late");
    AST_CLR: assert property ($fell(overflow_flag) |-> $past(clr))
        else $error("flag cleared without write");
    AST_UNMAP: assert property (dr && da > 12'h010 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CTRL: assert property (dr && da == 12'h008 |-> hrdata == {24'h0, csh & 8'hfd})
        else $error("control readback wrong");
    AST_GRD: assert property (dr && da == 12'h00c |-> hrdata == {24'h0, gsh & 8'hcf})
        else $error("gate readback wrong");
endmodule  // gtmr_monitor
bind gtmr_timer gtmr_monitor mon (.*);

// ==== sim/gated_16bit_timer_test.sv ====
// Register-level bench for the gated timer.
`timescale 1ns/10ps
module gated_16bit_timer_test;
    localparam [63:0] GV = 64'h80c0c2c383c6c140;
    localparam [7:0] GE = 8'hb6;
    reg hclk, hresetn, hsel, hwrite, lfo, sleep_mode;
    reg [11:0] haddr;
    reg [1:0] htrans, lfo_div;
    reg [31:0] hwdata;
    reg [7:0] c;
    wire hreadyout, hresp, ext_clk, gate_pin, cmp1, cmp2, nbr;
    wire sec_osc_run, overflow_flag, wake_request, gate_level;
    wire [31:0] hrdata;
    integer n_mismatch, n_tests, cyc, s, p;
    gtmr_pins pins (.ext_clock_pin(ext_clk), .gate_pin(gate_pin), .cmp1_out(cmp1),
        .cmp2_out(cmp2), .nbr_ovf(nbr));
    gtmr_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_clock_pin(ext_clk),
        .low_freq_internal_osc(lfo), .sec_osc_clock(lfo), .gate_pin(gate_pin),
        .neighbour_8bit_timer_ovf(nbr), .cmp1_out(cmp1), .cmp2_out(cmp2),
        .sleep_mode(sleep_mode), .sec_osc_run(sec_osc_run), .overflow_flag(overflow_flag),
        .wake_request(wake_request), .gate_level(gate_level));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Slow oscillator stand-in: one single-cycle pulse every four clocks.
    always @(posedge hclk) begin
        lfo_div <= lfo_div + 2'h1;
        lfo <= lfo_div == 2'h3;
    end
    // Cuts a hang short; the whole run needs under ten thousand cycles.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            results;
        end
    end
    task results;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // A tolerance of one absorbs prescaler and divider phase.
    task chk(input string nm, input [31:0] e, input [31:0] g, input integer t);
        begin
            n_tests = n_tests + 1;
            if (^g === 1'bx || g > e + t || g + t < e) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task phase;
        begin
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
        end
    endtask
    task xfer(input [11:0] a, input w, input [7:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            haddr <= a;
            hwrite <= w;
            htrans <= 2'h2;
            phase;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= {24'h0, d};
            phase;
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        xfer(a, 1'b1, d);
    endtask
    task rc(input string nm, input [11:0] a, input [31:0] e, input integer t);
        begin
            xfer(a, 1'b0, 8'h00);
            chk(nm, e, hrdata, t);
        end
    endtask
    // Counts one window: from zero, run, then stop and read the low byte.
    task run(input [7:0] cr, input [7:0] g, input integer np, input [31:0] e);
        begin
            wr(12'h008, 8'h00);
            wr(12'h00c, g);
            wr(12'h000, 8'h00);
            wr(12'h004, 8'h00);
            wr(12'h008, cr);
            if (np > 0) begin
                pins.pulses(np);
                repeat (4) @(posedge hclk);
            end else
                repeat (61) @(posedge hclk);
            wr(12'h008, cr & 8'hfe);
            rc("count", 12'h000, e, np > 0 ? 0 : 1);
        end
    endtask
    initial begin
        {hresetn, hsel, hwrite, lfo, sleep_mode, haddr, htrans, lfo_div, hwdata} = 54'h0;
        n_mismatch = 0;
        n_tests = 0;
        cyc = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (s = 0; s < 6; s = s + 1)
            rc("reset", 12'(s * 4 + (s / 5) * 12), 32'h0, 0);
        $display("test reset done");
        wr(12'h000, 8'h34);
        wr(12'h004, 8'h12);
        repeat (20) @(posedge hclk);
        rc("low", 12'h000, 32'h34, 0);
        rc("high", 12'h004, 32'h12, 0);
        wr(12'h008, 8'hfe);
        wr(12'h00c, 8'hff);
        rc("ctrl", 12'h008, 32'hfc, 0);
        rc("gate", 12'h00c, 32'hcf, 0);
        chk("osc", 32'h1, {31'h0, sec_osc_run}, 0);
        $display("test access done");
        for (s = 0; s < 4; s = s + 1)
            for (p = 0; p < 4; p = p + 1) begin
                c = {s[1:0], p[1:0], 4'h1};
                if (s != 2)
                    run(c, 8'h00, 0, (s == 1 ? 32'd64 : 32'd16) >> p);
            end
        $display("test sources done");
        for (s = 0; s < 8; s = s + 1)
            run(8'h41, GV[63 - 8 * s -: 8], 0, GE[s] ? 32'd64 : 32'd0);
        wr(12'h00c, 8'hc1);
        wr(12'h000, 8'h00);
        wr(12'h008, 8'h41);
        pins.nbr_pulses(4);
        wr(12'h008, 8'h40);
        rc("nbr", 12'h000, 32'h4, 0);
        $display("test gate done");
        run(8'h81, 8'h00, 5, 32'h5);
        run(8'h85, 8'h00, 5, 32'h5);
        wr(12'h000, 8'hff);
        wr(12'h004, 8'hff);
        sleep_mode <= 1'b1;
        wr(12'h008, 8'h85);
        pins.pulses(3);
        repeat (4) @(posedge hclk);
        chk("wake", 32'h1, {31'h0, wake_request}, 0);
        wr(12'h008, 8'h84);
        rc("low", 12'h000, 32'h2, 0);
        rc("stat", 12'h010, 32'h3, 0);
        wr(12'h010, 8'h01);
        rc("stat", 12'h010, 32'h0, 0);
        sleep_mode <= 1'b0;
        $display("test overflow done");
        // Crystal stand-in: the flag must rise 1024 counts after a preload of fc00.
        wr(12'h000, 8'h00);
        wr(12'h004, 8'hfc);
        wr(12'h008, 8'h89);
        repeat (4000) @(posedge hclk);
        chk("early", 32'h0, {31'h0, overflow_flag}, 0);
        repeat (200) @(posedge hclk);
        chk("settled", 32'h1, {31'h0, overflow_flag}, 0);
        wr(12'h008, 8'h08);
        wr(12'h010, 8'h01);
        $display("test oscillator done");
        // A reset in mid-run must clear the count and the controls again.
        wr(12'h000, 8'h5a);
        wr(12'h008, 8'hb5);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rc("rst ctrl", 12'h008, 32'h0, 0);
        rc("rst low", 12'h000, 32'h0, 0);
        rc("rst stat", 12'h010, 32'h0, 0);
        $display("test mid-run reset done");
        results;
    end
endmodule  // gated_16bit_timer_test
